// >>> pwmsri_map.vh
// Register map, field positions and reset values of the PWM shadow read-back block
// Notes on behaviour
// - Shadows show settings applied in PWM domain
// - Capture source: four 2-bit fields, reset zero
// - Control bits 21:16 show applied burst enables
// - Control bits 5:0 active levels, reset 3Fh
// - Period shadow 16 bits, reset FFFFh
// - Prescale shadow 16 bits, reset FFFFh
// - Sync delay shadow 16 bits, reset zero
// - Six activation match shadows, reset zero
// - Six deactivation match shadows, reset zero
// - Shadows read-only; reserved bits read zero
// - Two active-high interrupt request outputs
// - Match/capture line and PWM-level line sources
// - PWM-level bits: overflow, transfer, update, trap
// - Match bits: activation 0-5, deactivation 6-11
// - Capture bits 0-3 for channels 0-3
`ifndef PWMSRI_MAP_VH
`define PWMSRI_MAP_VH
`define PWMSRI_CAPSRC_OFF 12'h000
`define PWMSRI_CTRL_OFF 12'h004
`define PWMSRI_PRD_OFF 12'h008
`define PWMSRI_PRESCALE_VALUE_OFF 12'h00C
`define PWMSRI_DLY_OFF 12'h010
`define PWMSRI_ACT_BASE 12'h014
`define PWMSRI_ACT_LAST 12'h028
`define PWMSRI_DEACT_BASE 12'h02C
`define PWMSRI_DEACT_LAST 12'h040
`define PWMSRI_ACT0_OFF 12'h014
`define PWMSRI_ACT1_OFF 12'h018
`define PWMSRI_ACT2_OFF 12'h01C
`define PWMSRI_ACT3_OFF 12'h020
`define PWMSRI_ACT4_OFF 12'h024
`define PWMSRI_ACT5_OFF 12'h028
`define PWMSRI_DEACT0_OFF 12'h02C
`define PWMSRI_DEACT1_OFF 12'h030
`define PWMSRI_DEACT2_OFF 12'h034
`define PWMSRI_DEACT3_OFF 12'h038
`define PWMSRI_DEACT4_OFF 12'h03C
`define PWMSRI_DEACT5_OFF 12'h040
`define PWMSRI_PWM_STAT_OFF 12'h050
`define PWMSRI_PWM_EN_OFF 12'h054
`define PWMSRI_PWM_CLR_OFF 12'h058
`define PWMSRI_MTCH_STAT_OFF 12'h060
`define PWMSRI_MTCH_EN_OFF 12'h064
`define PWMSRI_MTCH_CLR_OFF 12'h068
`define PWMSRI_CAPT_STAT_OFF 12'h070
`define PWMSRI_CAPT_EN_OFF 12'h074
`define PWMSRI_CAPT_CLR_OFF 12'h078
`define PWMSRI_BURST_MSB 21
`define PWMSRI_BURST_LSB 16
`define PWMSRI_LVL_MSB 5
`define PWMSRI_LVL_LSB 0
`define PWMSRI_CAPSRC_RST 8'h00
`define PWMSRI_BURST_RST 6'h00
`define PWMSRI_LVL_RST 6'h3F
`define PWMSRI_PRD_RST 16'hFFFF
`define PWMSRI_PRESCALE_VALUE_RST 16'hFFFF
`define PWMSRI_DLY_RST 16'h0000
`define PWMSRI_MATCH_RST 96'h0
`define PWMSRI_OVF_BIT 0
`define PWMSRI_TD_BIT 1
`define PWMSRI_UD_BIT 2
`define PWMSRI_TRAP_BIT 3
`endif

// >>> pwmsri_top.v
// PWM shadow read-back registers and interrupt source mapping with APB slave
`timescale 1ns/1ps
`include "pwmsri_map.vh"

module pwmsri_irq_grp #(
  parameter W = 4
) (
  input wire clk,
  input wire rst_sync_b,
  input wire [W-1:0] set_pulse,
  input wire [W-1:0] clr_bits,
  input wire clr_wr,
  input wire [W-1:0] en_bits,
  output reg [W-1:0] status_q,
  output wire req
);
  wire [W-1:0] status_d;

  // Set wins over a clear in the same cycle so no event is lost
  assign status_d = (status_q & ~(clr_wr ? clr_bits : {W{1'b0}})) | set_pulse;
  assign req = |(status_q & en_bits);

  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      status_q <= {W{1'b0}};
    end else begin
      status_q <= status_d;
    end
  end
endmodule // pwmsri_irq_grp

module pwmsri_top #(
  parameter ADDR_W = 12,
  parameter NOUT = 6
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // Settings as applied in the PWM domain
  input wire [7:0] capture_source_select,
  input wire [NOUT-1:0] burst_enable_mirror,
  input wire [NOUT-1:0] active_level_mirror,
  input wire [15:0] period_mirror,
  input wire [15:0] prescale_mirror,
  input wire [15:0] delay_mirror,
  input wire [16*NOUT-1:0] activation_match_mirror,
  input wire [16*NOUT-1:0] deactivation_match_mirror,
  // Event pulses from the PWM datapath
  input wire overflow_wrap_evt,
  input wire transfer_done_evt,
  input wire update_done_evt,
  input wire trap_emergency_evt,
  input wire [NOUT-1:0] activation_match_evt,
  input wire [NOUT-1:0] deactivation_match_evt,
  input wire [3:0] capture_evt,
  // Interrupt requests
  output wire intreq_capt_match,
  output wire intreq_pwm
);
  reg rst_meta_q;
  reg rst_sync_b;
  reg [7:0] cap_src_q;
  reg [NOUT-1:0] burst_q;
  reg [NOUT-1:0] lvl_q;
  reg [15:0] prd_q;
  reg [15:0] prescale_value_q;
  reg [15:0] dly_q;
  reg [16*NOUT-1:0] act_q;
  reg [16*NOUT-1:0] deact_q;
  reg [3:0] pwm_en_q;
  reg [2*NOUT-1:0] mtch_en_q;
  reg [3:0] capt_en_q;
  reg [31:0] rd_d;
  reg hit_d;
  wire [3:0] pwm_stat;
  wire [2*NOUT-1:0] mtch_stat;
  wire [3:0] capt_stat;
  wire [3:0] pwm_set;
  wire pwm_req;
  wire mtch_req;
  wire capt_req;
  wire setup;
  wire wr_acc;
  wire clr_pwm;
  wire clr_mtch;
  wire clr_capt;

  // Reset release through two flops; assertion stays asynchronous
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_b <= rst_meta_q;
    end
  end

  // Shadows follow the applied values every cycle, never the bus-side copies
  // One process per shadow keeps each reset value next to its register
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cap_src_q <= `PWMSRI_CAPSRC_RST;
    end else begin
      cap_src_q <= capture_source_select;
    end
  end

  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      burst_q <= `PWMSRI_BURST_RST;
    end else begin
      burst_q <= burst_enable_mirror;
    end
  end

  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      lvl_q <= `PWMSRI_LVL_RST;
    end else begin
      lvl_q <= active_level_mirror;
    end
  end

  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      prd_q <= `PWMSRI_PRD_RST;
    end else begin
      prd_q <= period_mirror;
    end
  end

  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      prescale_value_q <= `PWMSRI_PRESCALE_VALUE_RST;
    end else begin
      prescale_value_q <= prescale_mirror;
    end
  end

  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      dly_q <= `PWMSRI_DLY_RST;
    end else begin
      dly_q <= delay_mirror;
    end
  end

  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      act_q <= `PWMSRI_MATCH_RST;
    end else begin
      act_q <= activation_match_mirror;
    end
  end

  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      deact_q <= `PWMSRI_MATCH_RST;
    end else begin
      deact_q <= deactivation_match_mirror;
    end
  end

  // Zero-wait slave: data is latched in setup, so access completes at once
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign pready = 1'b1;

  // Clear strobes act only at the access edge
  assign clr_pwm = wr_acc && (paddr == `PWMSRI_PWM_CLR_OFF);
  assign clr_mtch = wr_acc && (paddr == `PWMSRI_MTCH_CLR_OFF);
  assign clr_capt = wr_acc && (paddr == `PWMSRI_CAPT_CLR_OFF);

  // Read decode; every unlisted bit stays zero
  always @* begin
    rd_d = 32'h0000_0000;
    hit_d = 1'b1;
    case (paddr)
      `PWMSRI_CAPSRC_OFF: begin
        rd_d[7:0] = cap_src_q;
      end
      `PWMSRI_CTRL_OFF: begin
        rd_d[`PWMSRI_BURST_MSB:`PWMSRI_BURST_LSB] = burst_q;
        rd_d[`PWMSRI_LVL_MSB:`PWMSRI_LVL_LSB] = lvl_q;
      end
      `PWMSRI_PRD_OFF: begin
        rd_d[15:0] = prd_q;
      end
      `PWMSRI_PRESCALE_VALUE_OFF: begin
        rd_d[15:0] = prescale_value_q;
      end
      `PWMSRI_DLY_OFF: begin
        rd_d[15:0] = dly_q;
      end
      `PWMSRI_PWM_STAT_OFF: begin
        rd_d[3:0] = pwm_stat;
      end
      `PWMSRI_PWM_EN_OFF: begin
        rd_d[3:0] = pwm_en_q;
      end
      `PWMSRI_MTCH_STAT_OFF: begin
        rd_d[2*NOUT-1:0] = mtch_stat;
      end
      `PWMSRI_MTCH_EN_OFF: begin
        rd_d[2*NOUT-1:0] = mtch_en_q;
      end
      `PWMSRI_CAPT_STAT_OFF: begin
        rd_d[3:0] = capt_stat;
      end
      `PWMSRI_CAPT_EN_OFF: begin
        rd_d[3:0] = capt_en_q;
      end
      `PWMSRI_PWM_CLR_OFF, `PWMSRI_MTCH_CLR_OFF, `PWMSRI_CAPT_CLR_OFF: begin
        rd_d = 32'h0000_0000;
      end
      // Match slots decoded one by one; no offset arithmetic on the bus path
      `PWMSRI_ACT0_OFF: begin
        rd_d[15:0] = act_q[15:0];
      end
      `PWMSRI_ACT1_OFF: begin
        rd_d[15:0] = act_q[31:16];
      end
      `PWMSRI_ACT2_OFF: begin
        rd_d[15:0] = act_q[47:32];
      end
      `PWMSRI_ACT3_OFF: begin
        rd_d[15:0] = act_q[63:48];
      end
      `PWMSRI_ACT4_OFF: begin
        rd_d[15:0] = act_q[79:64];
      end
      `PWMSRI_ACT5_OFF: begin
        rd_d[15:0] = act_q[95:80];
      end
      `PWMSRI_DEACT0_OFF: begin
        rd_d[15:0] = deact_q[15:0];
      end
      `PWMSRI_DEACT1_OFF: begin
        rd_d[15:0] = deact_q[31:16];
      end
      `PWMSRI_DEACT2_OFF: begin
        rd_d[15:0] = deact_q[47:32];
      end
      `PWMSRI_DEACT3_OFF: begin
        rd_d[15:0] = deact_q[63:48];
      end
      `PWMSRI_DEACT4_OFF: begin
        rd_d[15:0] = deact_q[79:64];
      end
      `PWMSRI_DEACT5_OFF: begin
        rd_d[15:0] = deact_q[95:80];
      end
      default: begin
        hit_d = 1'b0;
      end
    endcase
  end

  // Read data and error latched at setup; held through the access phase
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_d;
      pslverr <= ~hit_d;
    end
  end

  // Enable registers; writes to shadow offsets are dropped
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pwm_en_q <= 4'h0;
    end else if (wr_acc && (paddr == `PWMSRI_PWM_EN_OFF)) begin
      pwm_en_q <= pwdata[3:0];
    end
  end

  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mtch_en_q <= {2*NOUT{1'b0}};
    end else if (wr_acc && (paddr == `PWMSRI_MTCH_EN_OFF)) begin
      mtch_en_q <= pwdata[2*NOUT-1:0];
    end
  end

  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      capt_en_q <= 4'h0;
    end else if (wr_acc && (paddr == `PWMSRI_CAPT_EN_OFF)) begin
      capt_en_q <= pwdata[3:0];
    end
  end

  assign pwm_set[`PWMSRI_OVF_BIT] = overflow_wrap_evt;
  assign pwm_set[`PWMSRI_TD_BIT] = transfer_done_evt;
  assign pwm_set[`PWMSRI_UD_BIT] = update_done_evt;
  assign pwm_set[`PWMSRI_TRAP_BIT] = trap_emergency_evt;

  pwmsri_irq_grp #(.W(4)) u_pwm_grp (
    .clk(clk),
    .rst_sync_b(rst_sync_b),
    .set_pulse(pwm_set),
    .clr_bits(pwdata[3:0]),
    .clr_wr(clr_pwm),
    .en_bits(pwm_en_q),
    .status_q(pwm_stat),
    .req(pwm_req)
  );

  pwmsri_irq_grp #(.W(2*NOUT)) u_mtch_grp (
    .clk(clk),
    .rst_sync_b(rst_sync_b),
    .set_pulse({deactivation_match_evt, activation_match_evt}),
    .clr_bits(pwdata[2*NOUT-1:0]),
    .clr_wr(clr_mtch),
    .en_bits(mtch_en_q),
    .status_q(mtch_stat),
    .req(mtch_req)
  );

  pwmsri_irq_grp #(.W(4)) u_capt_grp (
    .clk(clk),
    .rst_sync_b(rst_sync_b),
    .set_pulse(capture_evt),
    .clr_bits(pwdata[3:0]),
    .clr_wr(clr_capt),
    .en_bits(capt_en_q),
    .status_q(capt_stat),
    .req(capt_req)
  );

  // Match and capture share one line; PWM-level events use the other
  assign intreq_capt_match = mtch_req | capt_req;
  assign intreq_pwm = pwm_req;
endmodule // pwmsri_top

// >>> pwmsri_props.sv
// Port assertions for the PWM shadow read-back block
`timescale 1ns/1ps
`include "pwmsri_map.vh"
module pwmsri_props #(
  parameter ADDR_W = 12,
  parameter NOUT = 6
) (
  // Clock, reset and bus
  input wire clk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] prdata,
  input wire pslverr,
  // Applied settings and events
  input wire [7:0] capture_source_select,
  input wire [NOUT-1:0] burst_enable_mirror,
  input wire [NOUT-1:0] active_level_mirror,
  input wire [15:0] period_mirror,
  input wire overflow_wrap_evt,
  input wire transfer_done_evt,
  input wire update_done_evt,
  input wire trap_emergency_evt,
  input wire [NOUT-1:0] activation_match_evt,
  input wire [NOUT-1:0] deactivation_match_evt,
  input wire [3:0] capture_evt,
  // Requests
  input wire intreq_capt_match,
  input wire intreq_pwm
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire setup_rd = psel && !penable && !pwrite;
  wire wr_done = psel && penable && pwrite;
  wire pwm_evt = overflow_wrap_evt | transfer_done_evt | update_done_evt | trap_emergency_evt;
  wire cm_evt = |{activation_match_evt, deactivation_match_evt, capture_evt};
  // Cycles since reset release; shadows hold reset values until count 3
  reg [1:0] up_q;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  ctrl_reset_a: assert property (
    setup_rd && up_q == 2'h2 && paddr == `PWMSRI_CTRL_OFF |=>
    prdata == 32'h0000003F) else $error("ctrl reset value wrong");
  period_reset_a: assert property (
    setup_rd && up_q == 2'h2 && paddr == `PWMSRI_PRD_OFF |=>
    prdata == 32'h0000FFFF) else $error("period reset value wrong");
  // Shadow holds the mirror of the edge before setup
  capsrc_read_a: assert property (
    setup_rd && up_q == 2'h3 && paddr == `PWMSRI_CAPSRC_OFF |=>
    prdata == {24'h000000, $past(capture_source_select, 2)}) else $error("capsrc read wrong");
  ctrl_read_a: assert property (
    setup_rd && up_q == 2'h3 && paddr == `PWMSRI_CTRL_OFF |=> prdata == {10'h000,
    $past(burst_enable_mirror, 2), 10'h000, $past(active_level_mirror, 2)}) else $error("ctrl read wrong");
  period_read_a: assert property (
    setup_rd && up_q == 2'h3 && paddr == `PWMSRI_PRD_OFF |=>
    prdata == {16'h0000, $past(period_mirror, 2)}) else $error("period read wrong");
  unmapped_read_a: assert property (
    psel && !penable && paddr >= 12'h080 && paddr[1:0] == 2'h0 |=>
    pslverr && prdata == 32'h00000000) else $error("unmapped access not flagged");
  pwm_rise_a: assert property (
    $rose(intreq_pwm) |-> $past(pwm_evt) || $past(wr_done)) else $error("pwm request without cause");
  cm_rise_a: assert property (
    $rose(intreq_capt_match) |-> $past(cm_evt) || $past(wr_done)) else $error("cm request without cause");
  pwm_hold_a: assert property (
    $fell(intreq_pwm) |-> $past(wr_done)) else $error("pwm request dropped alone");
  cm_hold_a: assert property (
    $fell(intreq_capt_match) |-> $past(wr_done)) else $error("cm request dropped alone");
endmodule // pwmsri_props

// >>> pwmsri_vic_model.sv
// Interrupt controller front end seeing the two request levels
`timescale 1ns/1ps
module pwmsri_vic_model (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Request levels, active high; pending copies
  input wire [1:0] req_in,
  output reg [1:0] pend_q
);
  // One stage keeps latency under two clocks
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) pend_q <= 2'h0;
    else pend_q <= req_in;
  end
endmodule // pwmsri_vic_model

// >>> pwm_shadow_readback_irq_tb.sv
// Self-checking bench for the PWM shadow read-back block
`timescale 1ns/1ps
`include "pwmsri_map.vh"
module pwm_shadow_readback_irq_tb;
  reg clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 12'h000, base;
  reg [31:0] pwdata = 32'h00000000, m;
  reg [7:0] capsrc = 8'hE4;
  reg [5:0] burst = 6'h2A, lvl = 6'h15;
  reg [15:0] period_value = 16'hBEEF, prescale_value = 16'h7ACE, dly = 16'h0C1D;
  reg [95:0] act, deact;
  reg [3:0] pev = 4'h0, cev = 4'h0;
  reg [11:0] mev = 12'h000;
  wire pready, pslverr, irq_cm, irq_pwm;
  wire [31:0] prdata;
  wire [1:0] pend;
  integer n_errors = 0, checks_done = 0, i, g, b;
  always #12.5 clk = ~clk;
  pwmsri_top uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .capture_source_select(capsrc), .burst_enable_mirror(burst), .active_level_mirror(lvl),
    .period_mirror(period_value), .prescale_mirror(prescale_value), .delay_mirror(dly),
    .activation_match_mirror(act), .deactivation_match_mirror(deact),
    .overflow_wrap_evt(pev[0]), .transfer_done_evt(pev[1]), .update_done_evt(pev[2]),
    .trap_emergency_evt(pev[3]), .activation_match_evt(mev[5:0]),
    .deactivation_match_evt(mev[11:6]), .capture_evt(cev),
    .intreq_capt_match(irq_cm), .intreq_pwm(irq_pwm));
  pwmsri_vic_model vic (.clk(clk), .rst_b(rst_b), .req_in({irq_pwm, irq_cm}), .pend_q(pend));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Setup then access; held until pready seen high
  task xfer(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 1'b0; penable <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] exp);
    begin
      xfer(1'b0, a, 32'h00000000);
      chk(prdata, exp);
    end
  endtask
  // Mid-run reset, then a read whose setup lands on the 3rd edge after release
  task rst_rd(input [11:0] a, input [31:0] exp);
    begin
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(a, exp);
    end
  endtask
  task ev(input integer grp, input integer bit_n);
    begin
      @(posedge clk);
      if (grp == 0) pev[bit_n] <= 1'b1;
      else if (grp == 1) mev[bit_n] <= 1'b1;
      else cev[bit_n] <= 1'b1;
      @(posedge clk);
      pev <= 4'h0; mev <= 12'h000; cev <= 4'h0;
    end
  endtask
  task summarize;
    begin
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    #1000000;
    n_errors = n_errors + 1;
    summarize;
  end
  initial begin
    for (i = 0; i < 6; i = i + 1) begin
      act[16*i+:16] = 16'hA000 + i[15:0];
      deact[16*i+:16] = 16'h5F00 + i[15:0];
    end
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`PWMSRI_CAPSRC_OFF, {24'h000000, capsrc});
    rd(`PWMSRI_CTRL_OFF, {10'h000, burst, 10'h000, lvl});
    rd(`PWMSRI_PRESCALE_VALUE_OFF, {16'h0000, prescale_value});
    rd(`PWMSRI_DLY_OFF, {16'h0000, dly});
    for (i = 0; i < 6; i = i + 1) begin
      rd(12'(`PWMSRI_ACT_BASE + 4 * i), {16'h0000, act[16*i+:16]});
      rd(12'(`PWMSRI_DEACT_BASE + 4 * i), {16'h0000, deact[16*i+:16]});
    end
    // Bus write must not reach the applied value
    xfer(1'b1, `PWMSRI_PRD_OFF, 32'hFFFFFFFF);
    @(posedge clk);
    period_value <= 16'h1234;
    rd(`PWMSRI_PRD_OFF, 32'h00001234);
    rd(12'h100, 32'h00000000);
    chk({31'h0, pslverr}, 32'h00000001);
    chk({31'h0, pready}, 32'h00000001);
    for (g = 0; g < 3; g = g + 1) begin
      base = (g == 0) ? `PWMSRI_PWM_STAT_OFF : (g == 1) ? `PWMSRI_MTCH_STAT_OFF : `PWMSRI_CAPT_STAT_OFF;
      for (b = 0; b < ((g == 1) ? 12 : 4); b = b + 1) begin
        m = 32'h00000001 << b;
        ev(g, b);
        rd(base, m);
        chk({30'h0, pend}, 32'h00000000);
        xfer(1'b1, base + 12'h004, m);
        repeat (2) @(posedge clk);
        chk({30'h0, pend}, (g == 0) ? 32'h00000002 : 32'h00000001);
        xfer(1'b1, base + 12'h008, m);
        repeat (2) @(posedge clk);
        chk({30'h0, pend}, 32'h00000000);
        rd(base, 32'h00000000);
      end
    end
    rst_rd(`PWMSRI_CTRL_OFF, 32'h0000003F);
    rst_rd(`PWMSRI_PRD_OFF, 32'h0000FFFF);
    rst_rd(`PWMSRI_PRESCALE_VALUE_OFF, 32'h0000FFFF);
    rst_rd(`PWMSRI_CAPSRC_OFF, 32'h00000000);
    rst_rd(`PWMSRI_DLY_OFF, 32'h00000000);
    rst_rd(`PWMSRI_ACT_BASE, 32'h00000000);
    rst_rd(`PWMSRI_DEACT_LAST, 32'h00000000);
    rd(`PWMSRI_PRD_OFF, 32'h00001234);
    summarize;
  end
endmodule // pwm_shadow_readback_irq_tb
bind pwmsri_top pwmsri_props #(.ADDR_W(ADDR_W), .NOUT(NOUT)) u_props (.clk, .rst_b, .psel,
  .penable, .pwrite, .paddr, .prdata, .pslverr, .capture_source_select, .burst_enable_mirror,
  .active_level_mirror, .period_mirror, .overflow_wrap_evt, .transfer_done_evt,
  .update_done_evt, .trap_emergency_evt, .activation_match_evt, .deactivation_match_evt,
  .capture_evt, .intreq_capt_match, .intreq_pwm);
